// File: core/sram_port_consts.vh
// Timing and encoding constants for the dual-port SRAM port controller.
// Assumes a 40 MHz system clock (25 ns period).
`ifndef SRAM_PORT_CONSTS_VH
`define SRAM_PORT_CONSTS_VH

// Clock period in ps
`define CLK_PERIOD_PS      25000
// Minimum intervals in ps, fastest grade
`define T_WC_PS            10000
`define T_EW_PS            8000
`define T_WP_PS            8000
`define T_DW_PS            6000
`define T_WZ_PS            4000
`define T_SWRD_PS          5000
`define T_AA_PS            10000
// Round-up to whole cycles, zero for a zero interval
`define CYC_UP(t)          (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Phase counter width
`define CNT_W              4
// Operation codes
`define OP_RAM_WR          2'h0
`define OP_RAM_RD          2'h1
`define OP_SEM_WR          2'h2
`define OP_SEM_RD          2'h3
// Idle and active pin levels for active-low strobes
`define PIN_IDLE           1'b1
`define PIN_ACT            1'b0

`endif

// File: core/phase_timer.v
// Down-counter that measures one phase of an SRAM cycle.
// Assumes load and load_val come from the sequencer in the same clock domain.
`timescale 1ns/1ps
module phase_timer
#(
  parameter W = 4
)
(
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg          done
);

  reg [W-1:0] cnt_r;
  reg [W-1:0] cnt_nxt;

  always @*
  begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = load_val;
    else if (cnt_r != {W{1'b0}})
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cnt_r <= {W{1'b0}};
      done  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done  <= (cnt_nxt == {W{1'b0}});
    end
  end

endmodule

// File: core/sram_port_ctrl.v
// Host-side controller for one port of an asynchronous dual-port SRAM.
// Assumes pin inputs are synchronous to clk_sys; the port's board wiring resolves the data bus.
`timescale 1ns/1ps
`include "sram_port_consts.vh"
module sram_port_ctrl
#(
  parameter AW = 17,
  parameter DW = 36,
  parameter BW = 4
)
(
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          req_valid,
  input  wire [1:0]    req_op,
  input  wire [AW-1:0] req_addr,
  input  wire [DW-1:0] req_wdata,
  input  wire [BW-1:0] req_lanes,
  output reg           req_ready,
  output reg           rsp_valid,
  output reg  [DW-1:0] rsp_rdata,
  output reg  [AW-1:0] mem_addr,
  output reg           chip_select_n,
  output reg           flag_select_n,
  output reg           write_strobe_n,
  output reg           output_enable_n,
  output reg  [BW-1:0] byte_lane_enable_n,
  output reg  [DW-1:0] data_out,
  output reg           data_oe,
  input  wire [DW-1:0] data_in,
  input  wire          busy_n
);

  // ==========================================================
  // Cycle counts
  // Write pulse covers strobe width, turn-off plus set-up, cycle and enable time
  localparam integer T_PULSE_A  = (`T_WP_PS > (`T_WZ_PS + `T_DW_PS)) ? `T_WP_PS : (`T_WZ_PS + `T_DW_PS);
  localparam integer T_PULSE_B  = (`T_WC_PS > `T_EW_PS) ? `T_WC_PS : `T_EW_PS;
  localparam integer T_PULSE_PS = (T_PULSE_A > T_PULSE_B) ? T_PULSE_A : T_PULSE_B;
  localparam integer N_WP_I     = `CYC_UP(T_PULSE_PS);
  localparam integer N_SW_I     = `CYC_UP(`T_SWRD_PS);
  localparam integer N_AA_I     = `CYC_UP(`T_AA_PS);
  localparam [`CNT_W-1:0] N_WP  = N_WP_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] N_SW  = N_SW_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] N_AA  = N_AA_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] N_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};

  // ==========================================================
  // States
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_SETUP = 3'h1;
  localparam [2:0] S_WRITE = 3'h2;
  localparam [2:0] S_RECOV = 3'h3;
  localparam [2:0] S_READ  = 3'h4;
  localparam [2:0] S_DONE  = 3'h5;

  reg  [2:0]        state_r;
  reg  [2:0]        state_nxt;
  reg  [1:0]        op_r;
  reg               sem_wr_r;
  reg               load;
  reg  [`CNT_W-1:0] load_val;
  wire              tmr_done;

  phase_timer #(.W(`CNT_W)) u_timer
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (load_val),
    .done     (tmr_done)
  );

  wire is_wr  = (op_r == `OP_RAM_WR) || (op_r == `OP_SEM_WR);
  wire is_sem = (op_r == `OP_SEM_WR) || (op_r == `OP_SEM_RD);
  wire req_sem_rd = (req_op == `OP_SEM_RD);

  // ==========================================================
  // Sequencer
  always @*
  begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = N_ONE;
    case (state_r)
      S_IDLE:
        // Flag read held off after a flag write
        if (req_valid && req_ready && !(req_sem_rd && sem_wr_r && !tmr_done))
        begin
          state_nxt = S_SETUP;
        end
      S_SETUP:
      begin
        // Address settled with strobes high, then strobes applied
        load = 1'b1;
        if (is_wr)
        begin
          load_val  = N_WP;
          state_nxt = S_WRITE;
        end
        else
        begin
          load_val  = N_AA;
          state_nxt = S_READ;
        end
      end
      S_WRITE:
        // Pulse covers turn-off plus data set-up and cycle time
        if (tmr_done)
        begin
          load      = 1'b1;
          load_val  = is_sem ? N_SW : N_ONE;
          state_nxt = S_RECOV;
        end
      S_RECOV:
        state_nxt = S_DONE;
      S_READ:
        // Wait out access time, and busy when asserted
        if (tmr_done && busy_n)
          state_nxt = S_DONE;
      S_DONE:
        state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // ==========================================================
  // Pin and response registers
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r            <= S_IDLE;
      op_r               <= `OP_RAM_RD;
      sem_wr_r           <= 1'b0;
      req_ready          <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= {DW{1'b0}};
      mem_addr           <= {AW{1'b0}};
      chip_select_n      <= `PIN_IDLE;
      flag_select_n      <= `PIN_IDLE;
      write_strobe_n     <= `PIN_IDLE;
      output_enable_n    <= `PIN_IDLE;
      byte_lane_enable_n <= {BW{1'b1}};
      data_out           <= {DW{1'b0}};
      data_oe            <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      rsp_valid <= 1'b0;
      req_ready <= (state_nxt == S_IDLE);
      case (state_r)
        S_IDLE:
          if (state_nxt == S_SETUP)
          begin
            // Address moves only with all strobes high
            op_r               <= req_op;
            mem_addr           <= req_addr;
            data_out           <= req_wdata;
            byte_lane_enable_n <= ~req_lanes;
            req_ready          <= 1'b0;
          end
        S_SETUP:
        begin
          // Select and write strobe fall together on writes so RAM outputs stay off; reads drop output enable
          chip_select_n  <= is_sem;
          flag_select_n  <= ~is_sem;
          write_strobe_n <= ~is_wr;
          output_enable_n <= is_wr;
          // Data driven only once RAM outputs are off
          data_oe        <= is_wr;
        end
        S_WRITE:
          if (tmr_done)
          begin
            // Strobe and select rise together; data held one more cycle
            chip_select_n  <= `PIN_IDLE;
            flag_select_n  <= `PIN_IDLE;
            write_strobe_n <= `PIN_IDLE;
            sem_wr_r       <= is_sem;
          end
        S_RECOV:
        begin
          data_oe            <= 1'b0;
          byte_lane_enable_n <= {BW{1'b1}};
        end
        S_READ:
          if (state_nxt == S_DONE)
          begin
            // Flag value appears on every data line
            rsp_rdata          <= data_in;
            rsp_valid          <= 1'b1;
            chip_select_n      <= `PIN_IDLE;
            flag_select_n      <= `PIN_IDLE;
            output_enable_n    <= `PIN_IDLE;
            byte_lane_enable_n <= {BW{1'b1}};
            sem_wr_r           <= 1'b0;
          end
        S_DONE:
          rsp_valid <= is_wr;
        default:
          rsp_valid <= 1'b0;
      endcase
    end
  end

endmodule

// File: sim/sram_port_monitor.sv
// Pin-level checker for one SRAM port controller.
// Assumes it is bound to sram_port_ctrl and sees only its ports.
`timescale 1ns/1ps
module sram_port_monitor
#(
  parameter AW = 17
)
(
  input wire          clk_sys,
  input wire          rst_n,
  input wire          req_valid,
  input wire [1:0]    req_op,
  input wire          req_ready,
  input wire          rsp_valid,
  input wire [AW-1:0] mem_addr,
  input wire          chip_select_n,
  input wire          flag_select_n,
  input wire          write_strobe_n,
  input wire          output_enable_n,
  input wire          data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // Pin sequencing
  a_sel_exclusive: assert property (!write_strobe_n |-> chip_select_n != flag_select_n)
    else $error("write without exactly one select");
  a_addr_quiet: assert property (!$stable(mem_addr) |-> $past(write_strobe_n) && $past(chip_select_n))
    else $error("address moved while strobes active");
  a_oe_off_write: assert property (data_oe || !write_strobe_n |-> output_enable_n)
    else $error("output enable low during write");
  a_data_cover: assert property (!write_strobe_n |-> data_oe)
    else $error("write data not driven under strobe");
  a_data_hold: assert property ($rose(write_strobe_n) |-> data_oe)
    else $error("write data released before write end");
  a_sel_lead: assert property ($rose(write_strobe_n) |-> !$past(chip_select_n) || !$past(flag_select_n))
    else $error("select not held to write end");
  a_idle_pins: assert property (req_ready |-> write_strobe_n && chip_select_n && flag_select_n && !data_oe)
    else $error("pins active while idle");
  a_write_answer: assert property (req_valid && req_ready && !req_op[0] |-> ##[4:8] rsp_valid)
    else $error("write not answered in time");
  a_one_request: assert property (req_valid && req_ready |=> !req_ready)
    else $error("second request taken while busy");
  c_ram_write: cover property (!write_strobe_n && !chip_select_n);
  c_flag_write: cover property (!write_strobe_n && !flag_select_n);
  c_flag_read: cover property (!output_enable_n && !flag_select_n);
endmodule
bind sram_port_ctrl sram_port_monitor #(.AW(AW)) i_mon (.clk_sys, .rst_n, .req_valid, .req_op, .req_ready,
  .rsp_valid, .mem_addr, .chip_select_n, .flag_select_n, .write_strobe_n, .output_enable_n, .data_oe);

// File: sim/sram_port_model.sv
// Behavioural model of one RAM port: array, eight flags, busy.
// Assumes pins change just after rising clk_sys edges.
`timescale 1ns/1ps
module sram_port_model
(
  input  wire         clk_sys,
  input  wire  [16:0] mem_addr,
  input  wire         chip_select_n,
  input  wire         flag_select_n,
  input  wire         write_strobe_n,
  input  wire         output_enable_n,
  input  wire  [3:0]  byte_lane_enable_n,
  input  wire  [35:0] data_out,
  input  wire         data_oe,
  input  wire         busy_hold,
  input  wire         rival_write,
  output logic [35:0] data_in,
  output wire         busy_n
);
  logic [35:0] mem [0:255];
  logic [7:0]  flag_r = 8'hFF;
  logic [35:0] last_r = 36'h0;
  integer      i;
  wire         rd_on = !output_enable_n && write_strobe_n && (!chip_select_n || !flag_select_n);
  // ==========
  // Storage and bus
  assign busy_n = !busy_hold;
  always @(negedge clk_sys)
  begin
    for (i = 0; i < 4; i = i + 1)
      if (!write_strobe_n && !chip_select_n && !byte_lane_enable_n[i])
        mem[mem_addr[7:0]][i*9 +: 9] <= data_out[i*9 +: 9];
    // Opposite port claiming the same flag in the same window wins it
    if (!write_strobe_n && !flag_select_n && chip_select_n)
      flag_r[mem_addr[2:0]] <= (rival_write && !data_out[0]) ? 1'b1 : data_out[0];
  end
  // Released bus toggles so stale data never passes
  always @*
  begin
    if (rd_on)
      data_in = !chip_select_n ? mem[mem_addr[7:0]] : {36{flag_r[mem_addr[2:0]]}};
    else if (data_oe)
      data_in = data_out;
    else
      data_in = ~last_r;
  end
  always @(posedge clk_sys)
    last_r <= data_in;
endmodule

// File: sim/dual_port_sram_write_semaphore_access_bench.sv
// Self-checking bench for sram_port_ctrl against the port model.
// Assumes the controller's default widths.
`timescale 1ns/1ps
module dual_port_sram_write_semaphore_access_bench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [16:0] req_addr = 17'h0;
  logic [35:0] req_wdata = 36'h0;
  logic [3:0]  req_lanes = 4'hF;
  logic        busy_hold = 1'b0;
  logic        rival_write = 1'b0;
  logic [35:0] exp_w;
  integer      bad_count = 0;
  integer      cmp_count = 0;
  integer      lat;
  wire  [35:0] rsp_rdata, data_out, data_in;
  wire  [16:0] mem_addr;
  wire  [3:0]  byte_lane_enable_n;
  wire         req_ready, rsp_valid, chip_select_n, flag_select_n;
  wire         write_strobe_n, output_enable_n, data_oe, busy_n;
  initial forever #12.5 clk_sys = ~clk_sys;
  sram_port_ctrl i_dut (.clk_sys, .rst_n, .req_valid, .req_op, .req_addr, .req_wdata, .req_lanes, .req_ready,
    .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n, .flag_select_n, .write_strobe_n, .output_enable_n,
    .byte_lane_enable_n, .data_out, .data_oe, .data_in, .busy_n);
  sram_port_model i_ram (.clk_sys, .mem_addr, .chip_select_n, .flag_select_n, .write_strobe_n,
    .output_enable_n, .byte_lane_enable_n, .data_out, .data_oe, .busy_hold, .rival_write, .data_in, .busy_n);
  // ==========
  // Shared tasks
  task chk(input [35:0] got, input [35:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task req(input [1:0] op, input [16:0] a, input [35:0] d, input [3:0] ln);
  begin
    {req_valid, req_op, req_addr, req_wdata, req_lanes} = {1'b1, op, a, d, ln};
    lat = 0;
    while (req_ready !== 1'b1 && lat < 50)
    begin
      @(negedge clk_sys);
      lat = lat + 1;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 60)
    begin
      @(negedge clk_sys);
      lat = lat + 1;
    end
    chk(lat < 60, 1'b1);
  end
  endtask
  // ==========
  // Scenarios
  task t_ram;
  begin
    exp_w = (36'h123456789 & ~36'h007FC01FF) | (36'hFEDCBA987 & 36'h007FC01FF);
    req(2'h0, 17'h1A5, 36'h123456789, 4'hF);
    req(2'h0, 17'h1A5, 36'hFEDCBA987, 4'h5);
    req(2'h1, 17'h1A5, 36'h0, 4'hF);
    chk(rsp_rdata, exp_w);
  end
  endtask
  task t_flag;
  begin
    req(2'h0, 17'h2, 36'h0AAAA5555, 4'hF);
    req(2'h2, 17'h2, 36'h0, 4'hF);
    req(2'h3, 17'h2, 36'h0, 4'hF);
    chk(rsp_rdata, 36'h0);
    req(2'h2, 17'h2, 36'h1, 4'hF);
    req(2'h3, 17'h2, 36'h0, 4'hF);
    chk(rsp_rdata, 36'hFFFFFFFFF);
    req(2'h1, 17'h2, 36'h0, 4'hF);
    chk(rsp_rdata, 36'h0AAAA5555);
    rival_write = 1'b1;
    req(2'h2, 17'h3, 36'h0, 4'hF);
    rival_write = 1'b0;
    req(2'h3, 17'h3, 36'h0, 4'hF);
    chk(rsp_rdata, 36'hFFFFFFFFF);
    req(2'h2, 17'h3, 36'h0, 4'hF);
    req(2'h3, 17'h3, 36'h0, 4'hF);
    chk(rsp_rdata, 36'h0);
  end
  endtask
  task t_busy;
  begin
    busy_hold = 1'b1;
    fork
      begin
        repeat (12) @(negedge clk_sys);
        busy_hold = 1'b0;
      end
    join_none
    req(2'h1, 17'h1A5, 36'h0, 4'hF);
    chk(lat > 8, 1'b1);
    chk(rsp_rdata, exp_w);
  end
  endtask
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({req_ready, write_strobe_n, chip_select_n, flag_select_n, data_oe}, 5'h1E);
    t_ram;
    t_flag;
    t_busy;
    give_verdict;
  end
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    give_verdict;
  end
endmodule
